// ---- hdl/fhs_pkg.sv ----
// Operation
// - Alt status bit0: direction inverted
// - Alt status bits1,2,4 inputs; bit3 side inverted
// - Alt status bit5 latches step, clears
// - Alt status bits6,7 show DRQ, interrupt
// - Status B readable enhanced, floats basic
// - Enhanced status B mirrors motors, write gate
// - Enhanced status B toggles on data edges
// - Enhanced status B bit5 shows select bit0
// - Enhanced status B bits 7:6 read one
// - Alt status B: ones, active-low selects
// - Alt status B bit2 latches write gate
// - Alt status B bits3,4 latch data edges
// - Motor control register zero, writable, survives
// - Bits 1:0 binary drive number
// - Bit2 low holds soft reset
// - Basic/alt: bit3 enables DMA/irq pins
// - Enhanced: DMA/irq pins always enabled
// - Bits 4,5 drive motor outputs
// - Tape assign bits 1:0, upper bits read zero
// - Normal order select and motor decode
// - Swapped order select and motor decode
// - Status A floats basic, readable enhanced
package fhs_pkg;
    localparam logic [9:0] ADDR_STATUS_A = 10'h3f0;
    localparam logic [9:0] ADDR_STATUS_B = 10'h3f1;
    localparam logic [9:0] ADDR_MOTOR_CTRL = 10'h3f2;
    localparam logic [9:0] ADDR_TAPE = 10'h3f3;
    localparam logic [9:0] ADDR_DIG_IN = 10'h3f7;
    localparam logic [7:0] MOTOR_CTRL_RESET = 8'h00;
    localparam logic [1:0] TAPE_RESET = 2'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] TAPE_DRIVE_MASK = 8'h03;
    localparam logic [1:0] DRIVE_NUM_0 = 2'h0;
    localparam logic [1:0] DRIVE_NUM_1 = 2'h1;
    localparam logic [1:0] RESERVED_ONES = 2'h3;

    typedef enum logic [1:0]
    {
        FHS_BASIC,
        FHS_ENHANCED,
        FHS_ALTERNATE
    } fhs_mode_type;

    // Field layout of the motor and drive control register
    typedef struct packed
    {
        logic motorOn3;
        logic motorOn2;
        logic motorOn1;
        logic motorOn0;
        logic dmaIrqPinEnable;
        logic softResetLow;
        logic [1:0] driveNum;
    } fhs_motor_ctrl_type;

    // Drive interface inputs, all active high after synchronising
    typedef struct packed
    {
        logic writeProtect;
        logic indexPulse;
        logic trackZeroIn;
        logic readData;
    } fhs_drive_in_type;

    // Drive interface signals the controller core produces
    typedef struct packed
    {
        logic stepOut;
        logic stepInward;
        logic headSideSel;
        logic writeGateOut;
        logic writeData;
        logic dmaRequest;
        logic floppyIrqOut;
    } fhs_core_out_type;
endpackage : fhs_pkg

// ---- hdl/floppy_host_status_output_regs.sv ----
`timescale 1ns/1ps
module fhs_floppy_host_status_output_regs
    import fhs_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire fhs_mode_type opMode,
    input wire logic swapDrives,
    input wire logic [9:0] hostAddr,
    input wire logic hostRead,
    input wire logic hostWrite,
    input wire logic [7:0] hostWriteData,
    input wire fhs_drive_in_type driveIn,
    input wire fhs_core_out_type coreOut,
    output logic [7:0] hostReadData,
    output logic hostDataOe,
    output logic driveSel0_n,
    output logic driveSel1_n,
    output logic motorOn0_n,
    output logic motorOn1_n,
    output logic coreReset,
    output logic dmaIrqPinsEnabled,
    output logic [1:0] tapeDriveNum
);
    // Drive pins cross from outside; two flops before use
    fhs_drive_in_type driveMeta;
    fhs_drive_in_type driveSync;
    logic readDataLast;
    logic writeDataLast;
    logic writeGateLast;
    logic stepLast;

    fhs_motor_ctrl_type motorCtrl;
    fhs_motor_ctrl_type next_motorCtrl;
    logic [1:0] tapeAssign;
    logic [1:0] next_tapeAssign;
    logic stepLatch;
    logic next_stepLatch;
    logic writeGateLatch;
    logic next_writeGateLatch;
    logic readEdgeFlag;
    logic next_readEdgeFlag;
    logic writeEdgeFlag;
    logic next_writeEdgeFlag;
    logic [7:0] next_hostReadData;
    logic next_hostDataOe;
    logic next_driveSel0_n;
    logic next_driveSel1_n;
    logic next_motorOn0_n;
    logic next_motorOn1_n;
    logic next_dmaIrqPinsEnabled;

    logic readFall;
    logic writeFall;
    logic writeGateRise;
    logic stepRise;
    logic digInRead;
    logic altMode;
    logic enhMode;

    // True when the host reads a given address this cycle
    function automatic logic readHit(input logic [9:0] a,
                                     input logic [9:0] target,
                                     input logic rd);
        readHit = rd && (a == target);
    endfunction : readHit

    // True when the host writes a given address this cycle
    function automatic logic writeHit(input logic [9:0] a,
                                      input logic [9:0] target,
                                      input logic wr);
        writeHit = wr && (a == target);
    endfunction : writeHit

    // Synchroniser and edge history
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            driveMeta <= '0;
            driveSync <= '0;
            readDataLast <= 1'b0;
            writeDataLast <= 1'b0;
            writeGateLast <= 1'b0;
            stepLast <= 1'b0;
        end
        else
        begin
            driveMeta <= driveIn;
            driveSync <= driveMeta;
            readDataLast <= driveSync.readData;
            writeDataLast <= coreOut.writeData;
            writeGateLast <= coreOut.writeGateOut;
            stepLast <= coreOut.stepOut;
        end
    end

    // Mode is a static strap from configuration
    assign altMode = (opMode == FHS_ALTERNATE);
    assign enhMode = (opMode == FHS_ENHANCED);
    // Inactive edge of an active-high data pulse is its fall
    assign readFall = readDataLast && !driveSync.readData;
    assign writeFall = writeDataLast && !coreOut.writeData;
    assign writeGateRise = !writeGateLast && coreOut.writeGateOut;
    assign stepRise = !stepLast && coreOut.stepOut;
    assign digInRead = readHit(hostAddr, ADDR_DIG_IN, hostRead);

    // Register file and event flags
    always_comb
    begin
        next_motorCtrl = motorCtrl;
        next_tapeAssign = tapeAssign;
        next_stepLatch = stepLatch;
        next_writeGateLatch = writeGateLatch;
        next_readEdgeFlag = readEdgeFlag;
        next_writeEdgeFlag = writeEdgeFlag;
        if (writeHit(hostAddr, ADDR_MOTOR_CTRL, hostWrite))
        begin
            next_motorCtrl = fhs_motor_ctrl_type'(hostWriteData);
        end
        if (writeHit(hostAddr, ADDR_TAPE, hostWrite))
        begin
            next_tapeAssign = hostWriteData[1:0];
        end
        // Clears first, so a same-cycle event still wins
        if (digInRead || !motorCtrl.softResetLow)
        begin
            next_stepLatch = 1'b0;
        end
        if (stepRise)
        begin
            next_stepLatch = 1'b1;
        end
        if (altMode)
        begin
            if (digInRead)
            begin
                next_writeGateLatch = 1'b0;
                next_readEdgeFlag = 1'b0;
                next_writeEdgeFlag = 1'b0;
            end
            if (writeGateRise)
            begin
                next_writeGateLatch = 1'b1;
            end
            if (readFall)
            begin
                next_readEdgeFlag = 1'b1;
            end
            // Not qualified by write gate on purpose
            if (writeFall)
            begin
                next_writeEdgeFlag = 1'b1;
            end
        end
        else
        begin
            if (readFall)
            begin
                next_readEdgeFlag = !readEdgeFlag;
            end
            if (writeFall)
            begin
                next_writeEdgeFlag = !writeEdgeFlag;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            motorCtrl <= fhs_motor_ctrl_type'(MOTOR_CTRL_RESET);
            tapeAssign <= TAPE_RESET;
            stepLatch <= 1'b0;
            writeGateLatch <= 1'b0;
            readEdgeFlag <= 1'b0;
            writeEdgeFlag <= 1'b0;
        end
        else
        begin
            motorCtrl <= next_motorCtrl;
            tapeAssign <= next_tapeAssign;
            stepLatch <= next_stepLatch;
            writeGateLatch <= next_writeGateLatch;
            readEdgeFlag <= next_readEdgeFlag;
            writeEdgeFlag <= next_writeEdgeFlag;
        end
    end

    // Drive decode and read mux
    always_comb
    begin
        logic sel0Raw;
        logic sel1Raw;
        logic [7:0] statA;
        logic [7:0] statB;
        sel0Raw = 1'b1;
        sel1Raw = 1'b1;
        statA = BYTE_ZERO;
        statB = BYTE_ZERO;
        // Binary number picks at most one drive (0 or 1), only with its motor bit set
        if (motorCtrl.driveNum == DRIVE_NUM_0 && motorCtrl.motorOn0)
        begin
            sel0Raw = 1'b0;
        end
        if (motorCtrl.driveNum == DRIVE_NUM_1 && motorCtrl.motorOn1)
        begin
            sel1Raw = 1'b0;
        end
        next_driveSel0_n = swapDrives ? sel1Raw : sel0Raw;
        next_driveSel1_n = swapDrives ? sel0Raw : sel1Raw;
        // Motor pins follow their bits, crossed when drives swap
        next_motorOn0_n = swapDrives ? !motorCtrl.motorOn1
                                     : !motorCtrl.motorOn0;
        next_motorOn1_n = swapDrives ? !motorCtrl.motorOn0
                                     : !motorCtrl.motorOn1;
        // Enhanced mode keeps the pins live regardless of the bit
        next_dmaIrqPinsEnabled = enhMode
                                 || motorCtrl.dmaIrqPinEnable;
        if (altMode)
        begin
            statA = {coreOut.floppyIrqOut, coreOut.dmaRequest,
                     stepLatch, driveSync.trackZeroIn,
                     !coreOut.headSideSel, driveSync.indexPulse,
                     driveSync.writeProtect,
                     !coreOut.stepInward};
            statB = {1'b1, next_driveSel1_n, next_driveSel0_n,
                     writeEdgeFlag, readEdgeFlag, writeGateLatch,
                     RESERVED_ONES};
        end
        else
        begin
            statA = {coreOut.floppyIrqOut, 1'b1, stepLatch,
                     !driveSync.trackZeroIn, coreOut.headSideSel,
                     !driveSync.indexPulse, !driveSync.writeProtect,
                     coreOut.stepInward};
            statB = {RESERVED_ONES, motorCtrl.driveNum[0],
                     writeEdgeFlag, readEdgeFlag,
                     coreOut.writeGateOut, motorCtrl.motorOn1,
                     motorCtrl.motorOn0};
        end
        next_hostReadData = BYTE_ZERO;
        next_hostDataOe = 1'b0;
        if (hostRead)
        begin
            case (hostAddr)
                ADDR_STATUS_A:
                begin
                    next_hostReadData = statA;
                    next_hostDataOe = !(opMode == FHS_BASIC);
                end
                ADDR_STATUS_B:
                begin
                    next_hostReadData = statB;
                    next_hostDataOe = !(opMode == FHS_BASIC);
                end
                ADDR_MOTOR_CTRL:
                begin
                    next_hostReadData = motorCtrl;
                    next_hostDataOe = 1'b1;
                end
                ADDR_TAPE:
                begin
                    // All lanes driven; upper six bits read zero
                    next_hostReadData = {6'h00, tapeAssign};
                    next_hostDataOe = 1'b1;
                end
                default:
                begin
                    next_hostReadData = BYTE_ZERO;
                    next_hostDataOe = 1'b0;
                end
            endcase
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hostReadData <= BYTE_ZERO;
            hostDataOe <= 1'b0;
            driveSel0_n <= 1'b1;
            driveSel1_n <= 1'b1;
            motorOn0_n <= 1'b1;
            motorOn1_n <= 1'b1;
            coreReset <= 1'b1;
            tapeDriveNum <= TAPE_RESET;
        end
        else
        begin
            hostReadData <= next_hostReadData;
            hostDataOe <= next_hostDataOe;
            driveSel0_n <= next_driveSel0_n;
            driveSel1_n <= next_driveSel1_n;
            motorOn0_n <= next_motorOn0_n;
            motorOn1_n <= next_motorOn1_n;
            coreReset <= !motorCtrl.softResetLow;
            tapeDriveNum <= tapeAssign;
        end
    end

    // Pin enable kept out of hardware reset: in enhanced mode the pins
    // stay live through reset, while the cleared control bit leaves
    // only the strap. Limitation: unknown until the first clock edge.
    always_ff @(posedge clk)
    begin
        dmaIrqPinsEnabled <= next_dmaIrqPinsEnabled;
    end
endmodule : fhs_floppy_host_status_output_regs

// ---- verification/fhs_checker.sv ----
`timescale 1ns/1ps
module fhs_checker
    import fhs_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire fhs_mode_type opMode,
    input wire logic swapDrives,
    input wire logic [9:0] hostAddr,
    input wire logic hostRead,
    input wire logic hostWrite,
    input wire logic [7:0] hostWriteData,
    input wire logic [7:0] hostReadData,
    input wire logic hostDataOe,
    input wire logic driveSel0_n,
    input wire logic driveSel1_n,
    input wire logic motorOn0_n,
    input wire logic coreReset,
    input wire logic dmaIrqPinsEnabled
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Control writes; pins follow two edges later
    logic ctlWr;
    logic [7:0] d;
    assign ctlWr = hostWrite && hostAddr == ADDR_MOTOR_CTRL;
    assign d = hostWriteData;

    sel_norm0_a: assert property (
        ctlWr && !swapDrives && d[1:0] == 2'h0 && d[4]
        |=> ##1 !driveSel0_n && driveSel1_n) else $error("select 0 wrong");
    sel_norm1_a: assert property (
        ctlWr && !swapDrives && d[1:0] == 2'h1 && d[5]
        |=> ##1 !driveSel1_n && driveSel0_n) else $error("select 1 wrong");
    sel_swap_a: assert property (
        ctlWr && swapDrives && d[1:0] == 2'h0 && d[4]
        |=> ##1 !driveSel1_n && driveSel0_n) else $error("swap select wrong");
    motor_norm_a: assert property (
        ctlWr && !swapDrives |=> ##1 motorOn0_n == !$past(d[4], 2))
        else $error("motor 0 wrong");
    soft_rst_a: assert property (
        ctlWr |=> ##1 coreReset == !$past(d[2], 2))
        else $error("soft reset wrong");
    pins_enh_a: assert property (
        opMode == FHS_ENHANCED && $past(reset_n) |-> dmaIrqPinsEnabled)
        else $error("pins not enabled");
    basic_float_a: assert property (
        hostRead && opMode == FHS_BASIC && hostAddr[9:1] == 9'h1f8
        |=> !hostDataOe) else $error("status driven in basic mode");
    resv_ones_a: assert property (
        hostRead && opMode == FHS_ENHANCED && hostAddr == ADDR_STATUS_B
        |=> hostDataOe && hostReadData[7:6] == RESERVED_ONES)
        else $error("reserved bits wrong");

    cover property (ctlWr && swapDrives);
    cover property (hostRead && hostAddr == ADDR_STATUS_B);
    cover property ($rose(coreReset));
endmodule : fhs_checker

bind fhs_floppy_host_status_output_regs fhs_checker fhs_checker_i (
    .clk(clk), .reset_n(reset_n), .opMode(opMode),
    .swapDrives(swapDrives), .hostAddr(hostAddr), .hostRead(hostRead),
    .hostWrite(hostWrite), .hostWriteData(hostWriteData),
    .hostReadData(hostReadData), .hostDataOe(hostDataOe),
    .driveSel0_n(driveSel0_n), .driveSel1_n(driveSel1_n),
    .motorOn0_n(motorOn0_n), .coreReset(coreReset),
    .dmaIrqPinsEnabled(dmaIrqPinsEnabled));

// ---- verification/fhs_drive_model.sv ----
`timescale 1ns/1ps
module fhs_drive_model
    import fhs_pkg::*;
(
    input wire logic clk,
    input wire logic readPulse,
    input wire logic [2:0] mediaIn,
    output fhs_drive_in_type driveIn
);
    // Media levels: protect, index, track zero; read pulse ends in a fall
    always_ff @(posedge clk)
    begin
        driveIn <= '{writeProtect: mediaIn[2], indexPulse: mediaIn[1],
            trackZeroIn: mediaIn[0], readData: readPulse};
    end
endmodule : fhs_drive_model

// ---- verification/test_floppy_host_status_output_regs.sv ----
`timescale 1ns/1ps
module test_floppy_host_status_output_regs;
    import fhs_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    fhs_mode_type opMode = FHS_BASIC;
    logic swapDrives = 1'b0;
    logic [9:0] hostAddr = 10'h000;
    logic hostRead = 1'b0;
    logic hostWrite = 1'b0;
    logic [7:0] hostWriteData = 8'h00;
    logic readPulse = 1'b0;
    logic [2:0] mediaIn = 3'h0;
    fhs_core_out_type coreOut = '0;
    fhs_drive_in_type driveIn;
    logic [7:0] hostReadData;
    logic hostDataOe, driveSel0_n, driveSel1_n, motorOn0_n, motorOn1_n;
    logic coreReset, dmaIrqPinsEnabled;
    logic [1:0] tapeDriveNum;
    int n_mismatch = 0;
    int comparisons = 0;
    // Per mode: status A; status B after 1c, edge, clear, 2d
    logic [7:0] expA [3] = '{8'h00, 8'h56, 8'h09};
    logic [7:0] expB [3][4] = '{'{4{8'h00}},
        '{8'hc1, 8'hc9, 8'hc9, 8'hea}, '{8'ha3, 8'hab, 8'ha3, 8'hc3}};
    // Per mode, core and media active: A, B, then A, B after clear
    logic [7:0] expC [3][4] = '{'{4{8'h00}},
        '{8'hed, 8'hdd, 8'hcd, 8'hdd}, '{8'hf2, 8'hb7, 8'hd2, 8'ha3}};

    always #12.5 clk = ~clk;

    fhs_drive_model fhs_drive_model_i (.clk(clk), .readPulse(readPulse),
        .mediaIn(mediaIn), .driveIn(driveIn));
    // Core outputs come straight from the bench, on its own timing
    fhs_floppy_host_status_output_regs fhs_floppy_host_status_output_regs_i (
        .clk(clk), .reset_n(reset_n), .opMode(opMode),
        .swapDrives(swapDrives), .hostAddr(hostAddr), .hostRead(hostRead),
        .hostWrite(hostWrite), .hostWriteData(hostWriteData),
        .driveIn(driveIn), .coreOut(coreOut), .hostReadData(hostReadData),
        .hostDataOe(hostDataOe), .driveSel0_n(driveSel0_n),
        .driveSel1_n(driveSel1_n), .motorOn0_n(motorOn0_n),
        .motorOn1_n(motorOn1_n), .coreReset(coreReset),
        .dmaIrqPinsEnabled(dmaIrqPinsEnabled), .tapeDriveNum(tapeDriveNum));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge clk);
        #2;
        hostAddr = a;
        hostWriteData = v;
        hostWrite = 1'b1;
        @(posedge clk);
        #2;
        hostWrite = 1'b0;
    endtask : wr

    // Data is only compared when the bus is expected driven
    task automatic rd(input logic [9:0] a, input logic oe,
        input logic [7:0] v);
        @(posedge clk);
        #2;
        hostAddr = a;
        hostRead = 1'b1;
        @(posedge clk);
        #2;
        hostRead = 1'b0;
        chk({7'h00, hostDataOe}, {7'h00, oe});
        if (oe)
            chk(hostReadData, v);
    endtask : rd

    // Order: sel1, sel0, motor1, motor0, soft reset, pin enable
    task automatic pins(input logic [5:0] e);
        @(posedge clk);
        #2;
        chk({2'h0, driveSel1_n, driveSel0_n, motorOn1_n, motorOn0_n,
            coreReset, dmaIrqPinsEnabled}, {2'h0, e});
    endtask : pins

    task automatic give_verdict();
        if (n_mismatch == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // Mode is static, so each mode gets its own hardware reset
    initial
    begin
        for (int m = 0; m < 3; m++)
        begin
            reset_n = 1'b0;
            coreOut = '0;
            mediaIn = 3'h0;
            opMode = fhs_mode_type'(m);
            swapDrives = (m == 2);
            repeat (4) @(posedge clk);
            #2;
            reset_n = 1'b1;
            rd(ADDR_MOTOR_CTRL, 1'b1, MOTOR_CTRL_RESET);
            pins({5'h1f, m == 1});
            wr(ADDR_MOTOR_CTRL, 8'h1c);
            pins(m == 2 ? 6'h15 : 6'h29);
            rd(ADDR_STATUS_A, m != 0, expA[m]);
            rd(ADDR_STATUS_B, m != 0, expB[m][0]);
            @(posedge clk);
            #2;
            readPulse = 1'b1;
            repeat (3) @(posedge clk);
            #2;
            readPulse = 1'b0;
            repeat (6) @(posedge clk);
            rd(ADDR_STATUS_B, m != 0, expB[m][1]);
            rd(ADDR_DIG_IN, 1'b0, 8'h00);
            rd(ADDR_STATUS_B, m != 0, expB[m][2]);
            wr(ADDR_MOTOR_CTRL, 8'h2d);
            pins(m == 2 ? 6'h29 : 6'h15);
            rd(ADDR_STATUS_B, m != 0, expB[m][3]);
            wr(ADDR_MOTOR_CTRL, 8'h29);
            pins(m == 2 ? 6'h2b : 6'h17);
            rd(ADDR_MOTOR_CTRL, 1'b1, 8'h29);
            wr(ADDR_MOTOR_CTRL, 8'h00);
            pins({5'h1f, m == 1});
            wr(ADDR_TAPE, 8'hff);
            rd(ADDR_TAPE, 1'b1, TAPE_DRIVE_MASK);
            chk({6'h00, tapeDriveNum}, 8'h03);
            rd(10'h3f6, 1'b0, 8'h00);
            // Core and media active, then step and write data drop
            wr(ADDR_MOTOR_CTRL, 8'h1c);
            coreOut = 7'h7f;
            mediaIn = 3'h5;
            @(posedge clk);
            #2;
            coreOut = 7'h3b;
            // Media levels need the model flop and two sync flops
            repeat (3) @(posedge clk);
            rd(ADDR_STATUS_A, m != 0, expC[m][0]);
            rd(ADDR_STATUS_B, m != 0, expC[m][1]);
            rd(ADDR_DIG_IN, 1'b0, 8'h00);
            rd(ADDR_STATUS_A, m != 0, expC[m][2]);
            rd(ADDR_STATUS_B, m != 0, expC[m][3]);
        end
        give_verdict();
    end

    // Run is about two hundred cycles; this leaves a wide margin
    initial
    begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
endmodule : test_floppy_host_status_output_regs
